// File: design/bcd_defs.svh
`ifndef BCD_DEFS_SVH
`define BCD_DEFS_SVH

// Register indices; byte address is four times the index
`define BCD_IDX_CTRL1     6'h20
`define BCD_IDX_STATUS    6'h21
`define BCD_IDX_TRACE     6'h24
`define BCD_IDX_TCOUNT    6'h25
`define BCD_IDX_CMP_CTRL  6'h28
`define BCD_IDX_ADDR_HI   6'h29
`define BCD_IDX_ADDR_MID  6'h2a
`define BCD_IDX_ADDR_LOW  6'h2b
`define BCD_IDX_DATA      6'h2c
`define BCD_IDX_MASK      6'h2d
`define BCD_IDX_EVT_STAT  6'h30
`define BCD_IDX_EVT_CLR   6'h31
`define BCD_IDX_EVT_EN    6'h32

// Control register 1 fields
`define BCD_C1_ARM        7
`define BCD_C1_FORCE_FINAL_STATE_BIT       6
`define BCD_C1_BRK_EN     4
`define BCD_C1_TRACE_EN   3

// Comparator control fields
`define BCD_CC_EN         0
`define BCD_CC_TAG        1
`define BCD_CC_RW_EN      2
`define BCD_CC_RW_VAL     3
`define BCD_CC_SZ_EN      4
`define BCD_CC_SZ_WORD    5
`define BCD_CC_TGT_LSB    6
`define BCD_CC_DATA_EN    8
`define BCD_CC_W          9

// Event bits
`define BCD_EV_FINAL      0
`define BCD_EV_BRK        1
`define BCD_EV_FULL       2
`define BCD_EV_W          3

// Reset values
`define BCD_RST_BYTE      8'h00
`define BCD_RST_CC        9'h000

`endif

// File: design/bcd_pkg.sv
package bcd_pkg;

	// Sequencer states, Gray along idle, state 1, state 2, final
	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b00,
		SEQ_ST1   = 2'b01,
		SEQ_ST2   = 2'b11,
		SEQ_FINAL = 2'b10
	} bcd_seq_t;

	// Comparator numbering
	typedef enum logic [1:0] {
		CMP_A = 2'h0,
		CMP_B = 2'h1,
		CMP_C = 2'h2
	} bcd_cmp_t;

endpackage : bcd_pkg

// File: design/bcd_comparator.sv
`timescale 1ns/1ps
`include "bcd_defs.svh"

module bcd_comparator #(
	parameter int ADDR_W   = 18,
	parameter int DATA_W   = 16,
	parameter bit HAS_DATA = 1'b0
) (
	// Configuration
	input  wire logic [ADDR_W-1:0]      cfg_addr_in,
	input  wire logic [`BCD_CC_W-1:0]   cfg_ctrl_in,
	input  wire logic [DATA_W-1:0]      cfg_data_in,
	input  wire logic [DATA_W-1:0]      cfg_mask_in,
	// Core bus
	input  wire logic [ADDR_W-1:0]      bus_addr_in,
	input  wire logic [DATA_W-1:0]      bus_data_in,
	input  wire logic                   bus_rw_in,
	input  wire logic                   bus_word_in,
	input  wire logic                   bus_valid_in,
	// Results
	output logic                        force_hit_out,
	output logic                        tag_hit_out
);
	if (ADDR_W < 17 || ADDR_W > 24) $error("bcd_comparator: ADDR_W must be 17..24");

	logic addr_ok;
	logic rw_ok;
	logic sz_ok;
	logic data_ok;
	logic hit;

	// Every address bit, each enabled qualifier and each unmasked, enabled data bit must agree in the same cycle
	assign addr_ok = (bus_addr_in == cfg_addr_in);
	assign rw_ok   = ~cfg_ctrl_in[`BCD_CC_RW_EN] |
	                 (bus_rw_in == cfg_ctrl_in[`BCD_CC_RW_VAL]);
	assign sz_ok   = ~cfg_ctrl_in[`BCD_CC_SZ_EN] |
	                 (bus_word_in == cfg_ctrl_in[`BCD_CC_SZ_WORD]);
	// Mask bit set drops that data bit from the compare
	assign data_ok = ~HAS_DATA | ~cfg_ctrl_in[`BCD_CC_DATA_EN] |
	                 (((bus_data_in ^ cfg_data_in) & ~cfg_mask_in) == '0);
	assign hit     = bus_valid_in & cfg_ctrl_in[`BCD_CC_EN] &
	                 addr_ok & rw_ok & sz_ok & data_ok;

	// Split by mode
	assign force_hit_out = hit & ~cfg_ctrl_in[`BCD_CC_TAG];
	assign tag_hit_out   = hit & cfg_ctrl_in[`BCD_CC_TAG];

endmodule : bcd_comparator

// File: design/bcd_trace_buf.sv
`timescale 1ns/1ps

module bcd_trace_buf #(
	parameter int W     = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic                     clk_in,
	input  wire logic                     rst_n_in,
	// Control
	input  wire logic                     clear_in,
	input  wire logic                     push_in,
	input  wire logic [W-1:0]             push_data_in,
	input  wire logic                     pop_in,
	// State
	output logic [W-1:0]                  rd_data_out,
	output logic [$clog2(DEPTH):0]        count_out,
	output logic                          full_out
);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("bcd_trace_buf: DEPTH must be 2^n");

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic          do_push;
	logic          do_pop;

	// Pushes stop at full; pops of an empty buffer do nothing
	assign do_push     = push_in & ~full_out;
	assign do_pop      = pop_in & (count_out != '0);
	assign full_out    = (count_out == DEPTH[AW:0]);
	assign rd_data_out = (count_out == '0) ? '0 : mem[rd_ptr];

	// Storage has no reset; only the pointers matter
	always_ff @(posedge clk_in) begin
		if (do_push)
			mem[wr_ptr] <= push_data_in;
	end

	// Pointers and fill count
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count_out <= '0;
		end else if (clear_in) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count_out <= '0;
		end else begin
			wr_ptr    <= wr_ptr + AW'(do_push);
			rd_ptr    <= rd_ptr + AW'(do_pop);
			count_out <= count_out + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

endmodule : bcd_trace_buf

// File: design/bcd_top.sv
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "bcd_defs.svh"

module bcd_top #(
	parameter int ADDR_W   = 18,
	parameter int DATA_W   = 16,
	parameter int TB_DEPTH = 16
) (
	// Clock and reset
	input  wire logic                 clk_sys_in,
	input  wire logic                 resetn_in,
	// Avalon-MM slave
	input  wire logic [7:0]           avs_address_in,
	input  wire logic                 avs_read_in,
	input  wire logic                 avs_write_in,
	input  wire logic [31:0]          avs_writedata_in,
	input  wire logic [3:0]           avs_byteenable_in,
	output logic [31:0]               avs_readdata_out,
	output logic                      avs_waitrequest_out,
	// Core buses, same clock
	input  wire logic [ADDR_W-1:0]    cpu_addr_in,
	input  wire logic [DATA_W-1:0]    cpu_data_in,
	input  wire logic                 cpu_rw_in,
	input  wire logic                 cpu_word_in,
	input  wire logic                 cpu_valid_in,
	input  wire logic                 cpu_exec_tag_in,
	input  wire logic [1:0]           cpu_exec_tag_id_in,
	// Core requests and status
	output logic                      cpu_tag_out,
	output logic [1:0]                cpu_tag_id_out,
	output logic                      brk_req_out,
	output logic                      trace_active_out,
	output logic                      irq_out
);
	if (ADDR_W < 17 || ADDR_W > 24) $error("bcd_top: ADDR_W must be 17..24");
	if (DATA_W != 16) $error("bcd_top: DATA_W must be 16");

	localparam int HI_W = ADDR_W - 16;
	localparam int CW   = $clog2(TB_DEPTH) + 1;

	// Reset synchroniser
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Control and configuration state
	logic                  arm;
	logic                  brk_en;
	logic                  trace_en;
	logic [1:0]            cmp_sel;
	bcd_pkg::bcd_seq_t     seq;
	bcd_pkg::bcd_seq_t     next_seq;
	logic [ADDR_W-1:0]     cmp_addr [3];
	logic [`BCD_CC_W-1:0]  cmp_ctrl [3];
	logic [DATA_W-1:0]     cmpa_data;
	logic [DATA_W-1:0]     cmpa_mask;
	logic [`BCD_EV_W-1:0]  evt_stat;
	logic [`BCD_EV_W-1:0]  evt_en;
	logic                  wait_q;

	// Bus decode: a transfer completes on the edge where waitrequest is low
	logic       accept;
	logic       wr_fire;
	logic       rd_fire;
	logic [5:0] idx;
	logic       be0;
	logic       be1;
	logic       cfg_open;

	assign accept   = (avs_read_in | avs_write_in) & ~wait_q;
	assign wr_fire  = avs_write_in & accept;
	assign rd_fire  = avs_read_in & accept;
	assign idx      = avs_address_in[7:2];
	assign be0      = avs_byteenable_in[0];
	assign be1      = avs_byteenable_in[1];
	assign cfg_open = wr_fire & ~arm;

	logic wr_ctrl1;
	logic wr_cc;
	logic wr_hi;
	logic wr_mid;
	logic wr_low;
	logic wr_data;
	logic wr_mask;
	logic wr_clr;
	logic wr_en;
	logic rd_trace;

	assign wr_ctrl1 = wr_fire & be0 & (idx == `BCD_IDX_CTRL1);
	assign wr_cc    = cfg_open & (idx == `BCD_IDX_CMP_CTRL);
	assign wr_hi    = cfg_open & be0 & (idx == `BCD_IDX_ADDR_HI);
	assign wr_mid   = cfg_open & be0 & (idx == `BCD_IDX_ADDR_MID);
	assign wr_low   = cfg_open & be0 & (idx == `BCD_IDX_ADDR_LOW);
	assign wr_data  = cfg_open & (idx == `BCD_IDX_DATA);
	assign wr_mask  = cfg_open & (idx == `BCD_IDX_MASK);
	assign wr_clr   = wr_fire & be0 & (idx == `BCD_IDX_EVT_CLR);
	assign wr_en    = wr_fire & be0 & (idx == `BCD_IDX_EVT_EN);
	// Each accepted read of the window takes one 16-bit entry
	assign rd_trace = rd_fire & (idx == `BCD_IDX_TRACE);

	// Comparators; only A carries the data compare
	logic [2:0] force_hit;
	logic [2:0] tag_hit;

	for (genvar i = 0; i < 3; i++) begin : g_cmp
		bcd_comparator #(
			.ADDR_W   (ADDR_W),
			.DATA_W   (DATA_W),
			.HAS_DATA (i == 0)
		) u_cmp (
			.cfg_addr_in   (cmp_addr[i]),
			.cfg_ctrl_in   (cmp_ctrl[i]),
			.cfg_data_in   (cmpa_data),
			.cfg_mask_in   (cmpa_mask),
			.bus_addr_in   (cpu_addr_in),
			.bus_data_in   (cpu_data_in),
			.bus_rw_in     (cpu_rw_in),
			.bus_word_in   (cpu_word_in),
			.bus_valid_in  (cpu_valid_in),
			.force_hit_out (force_hit[i]),
			.tag_hit_out   (tag_hit[i])
		);
	end

	// Match selection, A before B before C
	logic       fire;
	logic [1:0] fire_id;
	logic       tag_any;
	logic [1:0] tag_id;

	assign fire    = arm & (|force_hit | cpu_exec_tag_in);
	assign fire_id = force_hit[0] ? 2'h0 : force_hit[1] ? 2'h1 :
	                 force_hit[2] ? 2'h2 : cpu_exec_tag_id_in;
	assign tag_any = arm & (seq != bcd_pkg::SEQ_FINAL) & |tag_hit;
	assign tag_id  = tag_hit[0] ? 2'h0 : tag_hit[1] ? 2'h1 : 2'h2;

	// Session control
	logic force_final_state_bit;
	logic next_arm;
	logic done;
	logic enter_final;
	logic next_trace;
	logic next_trace_en;
	logic tb_full;
	logic tb_push;
	logic [DATA_W-1:0] tb_rd;
	logic [CW-1:0]     tb_cnt;
	logic [1:0]        tgt;

	// Trigger honours the arm value written in the same access
	assign force_final_state_bit        = wr_ctrl1 & avs_writedata_in[`BCD_C1_FORCE_FINAL_STATE_BIT] &
	                     avs_writedata_in[`BCD_C1_ARM];
	assign next_trace_en = wr_ctrl1 ? avs_writedata_in[`BCD_C1_TRACE_EN] : trace_en;
	// Completion disarms; no trace means complete on the cycle after entry
	assign done        = (seq == bcd_pkg::SEQ_FINAL) & ~trace_active_out;
	assign next_arm    = wr_ctrl1 ? avs_writedata_in[`BCD_C1_ARM] : (arm & ~done);
	assign tgt         = cmp_ctrl[fire_id][`BCD_CC_TGT_LSB +: 2];
	assign enter_final = (next_seq == bcd_pkg::SEQ_FINAL) & (seq != bcd_pkg::SEQ_FINAL);
	assign next_trace  = next_arm & ((enter_final & next_trace_en) |
	                     (trace_active_out & ~tb_full));
	assign tb_push     = trace_active_out & cpu_valid_in & arm;

	// Sequencer next state
	always_comb begin
		next_seq = (seq == bcd_pkg::SEQ_IDLE) ? bcd_pkg::SEQ_ST1 : seq;
		if (next_seq != bcd_pkg::SEQ_FINAL) begin
			if (force_final_state_bit)
				next_seq = bcd_pkg::SEQ_FINAL;
			else if (fire) begin
				case (tgt)
					2'h0:    next_seq = bcd_pkg::SEQ_ST1;
					2'h1:    next_seq = bcd_pkg::SEQ_ST2;
					default: next_seq = bcd_pkg::SEQ_FINAL;
				endcase
			end
		end
		if (!next_arm)
			next_seq = bcd_pkg::SEQ_IDLE;
	end

	bcd_trace_buf #(
		.W     (DATA_W),
		.DEPTH (TB_DEPTH)
	) u_tb (
		.clk_in       (clk_sys_in),
		.rst_n_in     (rst_n),
		.clear_in     (next_arm & ~arm),
		.push_in      (tb_push),
		.push_data_in (cpu_addr_in[15:0]),
		.pop_in       (rd_trace),
		.rd_data_out  (tb_rd),
		.count_out    (tb_cnt),
		.full_out     (tb_full)
	);

	// Events; a new event beats a clear in the same cycle
	logic [`BCD_EV_W-1:0] evt_set;
	logic [`BCD_EV_W-1:0] evt_clr;

	assign evt_set = {trace_active_out & tb_full, done & brk_en, enter_final};
	assign evt_clr = wr_clr ? avs_writedata_in[`BCD_EV_W-1:0] : '0;

	// Read mux, reads never wait on the sequencer
	logic [31:0] rd_mux;
	logic [7:0]  c1_rd;

	assign c1_rd  = {arm, 2'b00, brk_en, trace_en, 1'b0, cmp_sel};
	assign rd_mux =
		(idx == `BCD_IDX_CTRL1)    ? {24'h000000, c1_rd} :
		(idx == `BCD_IDX_STATUS)   ? {29'h0000000, trace_active_out, seq} :
		(idx == `BCD_IDX_TRACE)    ? {16'h0000, tb_rd} :
		(idx == `BCD_IDX_TCOUNT)   ? 32'(tb_cnt) :
		(idx == `BCD_IDX_CMP_CTRL) ? 32'(cmp_ctrl[cmp_sel]) :
		(idx == `BCD_IDX_ADDR_HI)  ? 32'(cmp_addr[cmp_sel][ADDR_W-1:16]) :
		(idx == `BCD_IDX_ADDR_MID) ? {24'h000000, cmp_addr[cmp_sel][15:8]} :
		(idx == `BCD_IDX_ADDR_LOW) ? {24'h000000, cmp_addr[cmp_sel][7:0]} :
		(idx == `BCD_IDX_DATA)     ? {16'h0000, cmpa_data} :
		(idx == `BCD_IDX_MASK)     ? {16'h0000, cmpa_mask} :
		(idx == `BCD_IDX_EVT_STAT) ? 32'(evt_stat) :
		(idx == `BCD_IDX_EVT_EN)   ? 32'(evt_en) : 32'h00000000;

	// Bus handshake: one wait cycle, then a single low cycle
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			wait_q           <= 1'b1;
			avs_readdata_out <= 32'h00000000;
		end else begin
			wait_q           <= ~(wait_q & (avs_read_in | avs_write_in));
			avs_readdata_out <= rd_mux;
		end
	end
	assign avs_waitrequest_out = wait_q;

	// Control register and sequencer
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			arm              <= 1'b0;
			brk_en           <= 1'b0;
			trace_en         <= 1'b0;
			cmp_sel          <= 2'h0;
			seq              <= bcd_pkg::SEQ_IDLE;
			trace_active_out <= 1'b0;
		end else begin
			arm              <= next_arm;
			seq              <= next_seq;
			trace_active_out <= next_trace;
			if (wr_ctrl1) begin
				brk_en   <= avs_writedata_in[`BCD_C1_BRK_EN];
				trace_en <= avs_writedata_in[`BCD_C1_TRACE_EN];
				cmp_sel  <= (avs_writedata_in[1:0] == 2'h3) ? 2'h2 : avs_writedata_in[1:0];
			end
		end
	end

	// Comparator configuration, frozen while armed
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++) begin
				cmp_addr[i] <= '0;
				cmp_ctrl[i] <= `BCD_RST_CC;
			end
			cmpa_data <= '0;
			cmpa_mask <= '0;
		end else begin
			if (wr_cc)
				cmp_ctrl[cmp_sel] <= avs_writedata_in[`BCD_CC_W-1:0];
			if (wr_hi)
				cmp_addr[cmp_sel][ADDR_W-1:16] <= avs_writedata_in[HI_W-1:0];
			if (wr_mid)
				cmp_addr[cmp_sel][15:8] <= avs_writedata_in[7:0];
			if (wr_low)
				cmp_addr[cmp_sel][7:0] <= avs_writedata_in[7:0];
			if (wr_data && be0)
				cmpa_data[7:0] <= avs_writedata_in[7:0];
			if (wr_data && be1)
				cmpa_data[15:8] <= avs_writedata_in[15:8];
			if (wr_mask && be0)
				cmpa_mask[7:0] <= avs_writedata_in[7:0];
			if (wr_mask && be1)
				cmpa_mask[15:8] <= avs_writedata_in[15:8];
		end
	end

	// Core requests, events and interrupt
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			cpu_tag_out    <= 1'b0;
			cpu_tag_id_out <= 2'h0;
			brk_req_out    <= 1'b0;
			evt_stat       <= '0;
			evt_en         <= '0;
			irq_out        <= 1'b0;
		end else begin
			cpu_tag_out    <= tag_any;
			cpu_tag_id_out <= tag_id;
			brk_req_out    <= done & brk_en & arm;
			evt_stat       <= (evt_stat & ~evt_clr) | evt_set;
			if (wr_en)
				evt_en <= avs_writedata_in[`BCD_EV_W-1:0];
			irq_out        <= |(((evt_stat & ~evt_clr) | evt_set) & evt_en);
		end
	end

endmodule : bcd_top

// File: tb/bcd_chk.sv
`timescale 1ns/1ps
`include "bcd_defs.svh"

module bcd_chk #(
	parameter int TB_DEPTH = 16
) (
	// Clock and reset
	input wire logic        clk_sys_in,
	input wire logic        resetn_in,
	// Register bus
	input wire logic [7:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic        avs_waitrequest_out,
	// Core side
	input wire logic        cpu_valid_in,
	input wire logic        cpu_tag_out,
	input wire logic        brk_req_out,
	input wire logic        trace_active_out,
	input wire logic        irq_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	// Writes as taken, at the edge that samples waitrequest low
	wire        wr_take = avs_write_in && !avs_waitrequest_out;
	wire        c1_wr   = wr_take && avs_address_in[7:2] == `BCD_IDX_CTRL1;
	wire        en_wr   = wr_take && avs_address_in[7:2] == `BCD_IDX_EVT_EN;
	wire        trg_wr  = c1_wr && avs_writedata_in[`BCD_C1_ARM] && avs_writedata_in[`BCD_C1_FORCE_FINAL_STATE_BIT];
	logic       armed_sw;
	logic       en_sw;
	logic [5:0] push_cnt;

	// Software view of arm and enables; auto-disarm only narrows the real arm
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			armed_sw <= 1'b0;
			en_sw    <= 1'b0;
		end else begin
			if (c1_wr) armed_sw <= avs_writedata_in[`BCD_C1_ARM];
			if (en_wr) en_sw <= |avs_writedata_in[`BCD_EV_W-1:0];
		end
	end

	// Core accesses in one trace session; above the depth is an overrun
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) push_cnt <= 6'h00;
		else if (!trace_active_out) push_cnt <= 6'h00;
		else if (cpu_valid_in) push_cnt <= push_cnt + 6'h01;
	end

	// Trigger write reaching final state, with and without trace
	sequence s_trace_up;
		##[1:2] trace_active_out;
	endsequence
	sequence s_brk_up;
		##[1:3] brk_req_out;
	endsequence

	a_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("request not answered");
	a_bus_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
	a_arm_gate: assert property ($rose(trace_active_out) || brk_req_out || cpu_tag_out
		|-> armed_sw) else $error("activity while disarmed");
	a_tag_cause: assert property (cpu_tag_out |-> $past(cpu_valid_in))
		else $error("tag without core access");
	a_brk_pulse: assert property (brk_req_out |=> !brk_req_out)
		else $error("breakpoint too long");
	a_brk_after_trace: assert property (brk_req_out |-> !trace_active_out)
		else $error("breakpoint during trace");
	a_trace_depth: assert property (trace_active_out |-> push_cnt <= TB_DEPTH)
		else $error("trace past buffer depth");
	a_force_final_state_bit_trace: assert property (trg_wr && avs_writedata_in[`BCD_C1_TRACE_EN]
		|-> s_trace_up) else $error("trigger gave no trace");
	a_force_final_state_bit_brk: assert property (trg_wr && avs_writedata_in[`BCD_C1_BRK_EN]
		&& !avs_writedata_in[`BCD_C1_TRACE_EN] |-> s_brk_up)
		else $error("trigger gave no breakpoint");
	a_irq_enable: assert property (irq_out |-> en_sw || $past(en_sw))
		else $error("irq with no event enabled");
endmodule : bcd_chk

bind bcd_top bcd_chk #(.TB_DEPTH(TB_DEPTH)) u_chk (
	.clk_sys_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in,
	.avs_writedata_in, .avs_waitrequest_out, .cpu_valid_in, .cpu_tag_out, .brk_req_out,
	.trace_active_out, .irq_out
);

// File: tb/bcd_core_model.sv
`timescale 1ns/1ps

module bcd_core_model #(
	parameter int ADDR_W   = 18,
	parameter int EXEC_DLY = 3
) (
	// Clock
	input  wire logic         clk_in,
	// Tag request from the debug unit
	input  wire logic         tag_in,
	input  wire logic [1:0]   tag_id_in,
	// Core buses
	output logic [ADDR_W-1:0] addr_out,
	output logic [15:0]       data_out,
	output logic              rw_out,
	output logic              word_out,
	output logic              valid_out,
	output logic              exec_out,
	output logic [1:0]        exec_id_out
);
	// Cleared by the bench to flush a tagged opcode
	logic       exec_ok  = 1'b1;
	int         wait_cnt = 0;
	logic [1:0] id_q     = 2'h0;

	initial begin
		addr_out    = '0;
		data_out    = 16'h0000;
		rw_out      = 1'b1;
		word_out    = 1'b1;
		valid_out   = 1'b0;
		exec_out    = 1'b0;
		exec_id_out = 2'h0;
	end

	// Tagged opcode reaches execution a fixed time later unless flushed
	always @(posedge clk_in) begin
		exec_out <= 1'b0;
		if (tag_in === 1'b1) begin
			wait_cnt <= exec_ok ? EXEC_DLY : 0;
			id_q     <= tag_id_in;
		end else if (wait_cnt == 1) begin
			exec_out    <= 1'b1;
			exec_id_out <= id_q;
			wait_cnt    <= 0;
		end else if (wait_cnt > 1) begin
			wait_cnt <= wait_cnt - 1;
		end
	end

	// One access strobe; the released bus shows the inverse so stale values never match
	task automatic access(input logic [ADDR_W-1:0] a, input logic [15:0] d,
		input logic rd, input logic wd);
		addr_out  <= a;
		data_out  <= d;
		rw_out    <= rd;
		word_out  <= wd;
		valid_out <= 1'b1;
		@(posedge clk_in);
		valid_out <= 1'b0;
		addr_out  <= ~a;
		data_out  <= ~d;
		@(posedge clk_in);
	endtask : access
endmodule : bcd_core_model

// File: tb/tb.sv
`timescale 1ns/1ps
`include "bcd_defs.svh"

module tb;
	localparam int DEPTH = 16;
	localparam logic [15:0] ARM = 16'h0001 << `BCD_C1_ARM, TRG = 16'h0001 << `BCD_C1_FORCE_FINAL_STATE_BIT;
	localparam logic [15:0] BRK = 16'h0001 << `BCD_C1_BRK_EN, TRC = 16'h0001 << `BCD_C1_TRACE_EN;
	localparam logic [15:0] CEN = 16'h0001 << `BCD_CC_EN, CTAG = 16'h0001 << `BCD_CC_TAG;
	localparam logic [15:0] CQ = 16'h003c, CDAT = 16'h0001 << `BCD_CC_DATA_EN;
	localparam logic [15:0] FIN = 16'h0002 << `BCD_CC_TGT_LSB;
	logic        clk_sys_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic [7:0]  avs_address_in = 8'h00;
	logic        avs_read_in = 1'b0;
	logic        avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0000_0000;
	logic [3:0]  avs_byteenable_in = 4'h0;
	logic [31:0] avs_readdata_out;
	logic [17:0] cpu_addr_in;
	logic [15:0] cpu_data_in;
	logic [1:0]  cpu_exec_tag_id_in, cpu_tag_id_out;
	logic        avs_waitrequest_out, cpu_rw_in, cpu_word_in, cpu_valid_in, cpu_exec_tag_in;
	logic        cpu_tag_out, brk_req_out, trace_active_out, irq_out;
	int          miscompares = 0, n_tests = 0, n_brk = 0;

	bcd_top #(.TB_DEPTH(DEPTH)) DUT (
		.clk_sys_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
		.cpu_addr_in, .cpu_data_in, .cpu_rw_in, .cpu_word_in, .cpu_valid_in,
		.cpu_exec_tag_in, .cpu_exec_tag_id_in, .cpu_tag_out, .cpu_tag_id_out,
		.brk_req_out, .trace_active_out, .irq_out
	);
	bcd_core_model core (
		.clk_in(clk_sys_in), .tag_in(cpu_tag_out), .tag_id_in(cpu_tag_id_out),
		.addr_out(cpu_addr_in), .data_out(cpu_data_in), .rw_out(cpu_rw_in),
		.word_out(cpu_word_in), .valid_out(cpu_valid_in), .exec_out(cpu_exec_tag_in),
		.exec_id_out(cpu_exec_tag_id_in)
	);

	// 10 MHz system clock
	always #50 clk_sys_in = ~clk_sys_in;

	// Breakpoint pulses seen, for scenarios to compare
	always @(posedge clk_sys_in) if (brk_req_out === 1'b1) n_brk++;

	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// One Avalon transfer, held until waitrequest is sampled low; reads use 16-bit lanes
	task automatic bus(input logic w, input logic [5:0] i, input logic [15:0] d,
		output logic [31:0] rd);
		avs_address_in    <= {i, 2'b00};
		avs_writedata_in  <= {16'h0000, d};
		avs_byteenable_in <= w ? 4'hf : 4'h3;
		avs_write_in      <= w;
		avs_read_in       <= !w;
		do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
		rd = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in  <= 1'b0;
		@(posedge clk_sys_in);
	endtask : bus

	task automatic wr(logic [5:0] i, logic [15:0] d);
		logic [31:0] x;
		bus(1'b1, i, d, x);
	endtask : wr

	task automatic rdc(string n, logic [5:0] i, logic [15:0] e);
		logic [31:0] x;
		bus(1'b0, i, 16'h0000, x);
		chk(n, e, x[15:0]);
	endtask : rdc

	// Interrupt is registered; look once the edge has landed
	task automatic chk_irq(logic e);
		@(negedge clk_sys_in);
		chk("irq", {15'h0000, e}, {15'h0000, irq_out});
		@(posedge clk_sys_in);
	endtask : chk_irq

	task automatic t_regs();
		for (int c = 0; c < 3; c++) begin
			wr(`BCD_IDX_CTRL1, 16'(c));
			rdc("mid_reset", `BCD_IDX_ADDR_MID, 16'h0000);
			wr(`BCD_IDX_ADDR_MID, 16'h00a0 + 16'(c));
			wr(`BCD_IDX_ADDR_LOW, 16'h0050 + 16'(c));
		end
		for (int c = 0; c < 3; c++) begin
			wr(`BCD_IDX_CTRL1, 16'(c));
			rdc("mid", `BCD_IDX_ADDR_MID, 16'h00a0 + 16'(c));
			rdc("low", `BCD_IDX_ADDR_LOW, 16'h0050 + 16'(c));
		end
		wr(`BCD_IDX_CTRL1, ARM);
		wr(`BCD_IDX_ADDR_MID, 16'h00ff);
		rdc("mid_armed", `BCD_IDX_ADDR_MID, 16'h00a0);
		rdc("state_armed", `BCD_IDX_STATUS, 16'(bcd_pkg::SEQ_ST1));
		wr(`BCD_IDX_CTRL1, 16'h0000);
		rdc("unmapped", 6'h3f, 16'h0000);
		$display("t_regs done");
	endtask : t_regs

	task automatic t_force();
		int b = n_brk;
		wr(`BCD_IDX_ADDR_HI, 16'h0000);
		wr(`BCD_IDX_ADDR_MID, 16'h0012);
		wr(`BCD_IDX_ADDR_LOW, 16'h0034);
		wr(`BCD_IDX_CMP_CTRL, CEN | CQ | FIN);
		wr(`BCD_IDX_EVT_EN, 16'h0007);
		wr(`BCD_IDX_CTRL1, ARM | TRC | BRK);
		// Near misses: low address byte, mid address byte, high bits, direction, size
		core.access(18'h01235, 16'h0000, 1'b1, 1'b1);
		core.access(18'h01334, 16'h0000, 1'b1, 1'b1);
		core.access(18'h11234, 16'h0000, 1'b1, 1'b1);
		core.access(18'h01234, 16'h0000, 1'b0, 1'b1);
		core.access(18'h01234, 16'h0000, 1'b1, 1'b0);
		chk("no_match", 16'h0000, 16'(trace_active_out));
		fork
			core.access(18'h01234, 16'h0000, 1'b1, 1'b1);
			begin
				@(posedge clk_sys_in);
				@(negedge clk_sys_in);
				chk("trace_same_access", 16'h0001, 16'(trace_active_out));
			end
		join
		repeat (DEPTH + 1) core.access(18'h01234, 16'h0000, 1'b1, 1'b1);
		repeat (3) @(posedge clk_sys_in);
		chk("trace_stopped", 16'h0000, 16'(trace_active_out));
		chk("brk_after_trace", 16'(b + 1), 16'(n_brk));
		rdc("count_full", `BCD_IDX_TCOUNT, 16'(DEPTH));
		rdc("entry", `BCD_IDX_TRACE, 16'h1234);
		rdc("count_pop", `BCD_IDX_TCOUNT, 16'(DEPTH - 1));
		rdc("events", `BCD_IDX_EVT_STAT, 16'h0007);
		chk_irq(1'b1);
		wr(`BCD_IDX_EVT_EN, 16'h0000);
		chk_irq(1'b0);
		wr(`BCD_IDX_EVT_EN, 16'h0007);
		chk_irq(1'b1);
		wr(`BCD_IDX_EVT_CLR, 16'h0007);
		rdc("events_clr", `BCD_IDX_EVT_STAT, 16'h0000);
		chk_irq(1'b0);
		// Session over and disarmed: a match now moves nothing
		core.access(18'h01234, 16'h0000, 1'b1, 1'b1);
		repeat (3) @(posedge clk_sys_in);
		chk("disarmed_brk", 16'(b + 1), 16'(n_brk));
		rdc("disarmed_state", `BCD_IDX_STATUS, 16'(bcd_pkg::SEQ_IDLE));
		$display("t_force done");
	endtask : t_force

	task automatic t_data();
		int b = n_brk;
		wr(`BCD_IDX_CMP_CTRL, CEN | FIN | CDAT);
		wr(`BCD_IDX_DATA, 16'h00ff);
		wr(`BCD_IDX_MASK, 16'h000f);
		wr(`BCD_IDX_CTRL1, ARM | BRK);
		core.access(18'h01234, 16'h01ff, 1'b1, 1'b1);
		repeat (3) @(posedge clk_sys_in);
		chk("data_miss", 16'(b), 16'(n_brk));
		core.access(18'h01234, 16'h00f3, 1'b1, 1'b1);
		repeat (3) @(posedge clk_sys_in);
		chk("data_masked_hit", 16'(b + 1), 16'(n_brk));
		$display("t_data done");
	endtask : t_data

	task automatic t_tag();
		int b = n_brk;
		wr(`BCD_IDX_CTRL1, 16'h0001);
		wr(`BCD_IDX_ADDR_MID, 16'h0000);
		wr(`BCD_IDX_ADDR_LOW, 16'h0040);
		wr(`BCD_IDX_CMP_CTRL, CEN | CTAG | FIN);
		core.exec_ok = 1'b0;
		wr(`BCD_IDX_CTRL1, ARM | BRK | 16'h0001);
		core.access(18'h00040, 16'h0000, 1'b1, 1'b1);
		repeat (8) @(posedge clk_sys_in);
		chk("tag_flushed", 16'(b), 16'(n_brk));
		rdc("tag_state", `BCD_IDX_STATUS, 16'(bcd_pkg::SEQ_ST1));
		core.exec_ok = 1'b1;
		core.access(18'h00040, 16'h0000, 1'b1, 1'b1);
		repeat (8) @(posedge clk_sys_in);
		chk("tag_executed", 16'(b + 1), 16'(n_brk));
		$display("t_tag done");
	endtask : t_tag

	task automatic t_seq();
		wr(`BCD_IDX_CTRL1, 16'h0002);
		wr(`BCD_IDX_ADDR_MID, 16'h0022);
		wr(`BCD_IDX_ADDR_LOW, 16'h0022);
		wr(`BCD_IDX_CMP_CTRL, CEN | (16'h0001 << `BCD_CC_TGT_LSB));
		wr(`BCD_IDX_CTRL1, ARM | 16'h0002);
		core.access(18'h02222, 16'h0000, 1'b1, 1'b1);
		rdc("seq_to_st2", `BCD_IDX_STATUS, 16'(bcd_pkg::SEQ_ST2));
		wr(`BCD_IDX_CTRL1, 16'h0000);
		$display("t_seq done");
	endtask : t_seq

	task automatic t_force_final_state_bit();
		int b = n_brk;
		wr(`BCD_IDX_CTRL1, TRG | BRK);
		repeat (4) @(posedge clk_sys_in);
		chk("force_final_state_bit_unarmed", 16'(b), 16'(n_brk));
		wr(`BCD_IDX_CTRL1, ARM | TRG | BRK);
		repeat (4) @(posedge clk_sys_in);
		chk("force_final_state_bit_brk", 16'(b + 1), 16'(n_brk));
		wr(`BCD_IDX_CTRL1, ARM | TRG | TRC);
		rdc("force_final_state_bit_final", `BCD_IDX_STATUS, 16'h0004 | 16'(bcd_pkg::SEQ_FINAL));
		wr(`BCD_IDX_CTRL1, 16'h0000);
		$display("t_force_final_state_bit done");
	endtask : t_force_final_state_bit

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	// Run takes well under 1000 cycles; this cuts a hang short
	initial begin
		repeat (5000) @(posedge clk_sys_in);
		miscompares++;
		wrap_up();
	end

	initial begin
		repeat (16) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		t_regs();
		t_force();
		t_data();
		t_tag();
		t_seq();
		t_force_final_state_bit();
		wrap_up();
	end
endmodule : tb
